/* dv/host_model.sv */
// host model driving the register request port of the bank
`timescale 1ns/1ps
module host_model
(
	// clock
	input wire logic core_clk,
	// register port
	output adc_ctrl_pkg::reg_req_t req,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid
);
	import adc_ctrl_pkg::*;
	// ****************
	// strobes
	// ****************
	initial req = '0;
	// released fields show inverted values, never stale ones
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge core_clk);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask
	task automatic get(input logic [7:0] a, output logic [7:0] d,
		output logic ok);
		ok = 1'b0;
		d = 'x;
		@(negedge core_clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge core_clk);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
		for (int n = 0; n < 4 && !ok; n++)
		begin
			if (reg_rvalid === 1'b1)
			begin
				d = reg_rdata;
				ok = 1'b1;
			end
			else
				@(negedge core_clk);
		end
	endtask
endmodule // host_model

/* dv/testbench.sv */
// self-checking bench of the converter control register bank
`timescale 1ns/1ps
module testbench;
	import adc_ctrl_pkg::*;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic pdwn_pin = 1'b0;
	logic [1:0][11:0] sample = {12'h456, 12'h123};
	logic [3:0][11:0] user_words = {12'h444, 12'h333, 12'h222, 12'h111};
	reg_req_t req;
	logic [7:0] reg_rdata;
	logic reg_rvalid;
	pwr_mode_t [1:0] pwr_state;
	logic dcs_active;
	logic div_tick;
	logic [1:0] test_active;
	logic [1:0][11:0] dout;
	int failures = 0;
	int compares = 0;
	int n;
	logic [11:0] prev;
	int tp [2];
	logic [7:0] ra [7] = '{8'h05, 8'h08, 8'h09, 8'h0B, 8'h0D, 8'hFF, 8'h20};
	logic [7:0] rv [7] = '{8'h03, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [3:0] tc [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h9};
	logic [11:0] te [5] = '{12'h123, 12'h800, 12'hFFF, 12'h000, 12'h000};
	logic [3:0] dc [5] = '{4'h4, 4'h7, 4'hF, 4'h5, 4'h6};
	always #12.5 core_clk = ~core_clk;
	adc_control_register_bank DUT (.core_clk(core_clk), .rstn(rstn),
		.req(req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.pdwn_pin(pdwn_pin), .sample(sample), .user_words(user_words),
		.pwr_state(pwr_state), .dcs_active(dcs_active),
		.div_tick(div_tick), .test_active(test_active), .dout(dout));
	host_model host (.core_clk(core_clk), .req(req),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
	// ****************
	// helpers
	// ****************
	task automatic give_verdict();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [11:0] e,
		input logic [11:0] g);
		compares++;
		if (g !== e)
		begin
			failures++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] v;
		logic ok;
		host.get(a, v, ok);
		if (ok !== 1'b1)
		begin
			failures++;
			give_verdict();
		end
		chk("reg_rdata", 12'(e), 12'(v));
	endtask
	// settle covers the registered lag behind the commit
	task automatic commit();
		host.put(8'hFF, 8'h01);
		repeat (4) @(negedge core_clk);
	endtask
	// ****************
	// sequence
	// ****************
	initial
	begin
		repeat (8) @(negedge core_clk);
		rstn = 1'b1;
		for (int i = 0; i < 7; i++)
			rd(ra[i], rv[i]);
		chk("dcs_active", 12'h001, 12'(dcs_active));
		host.put(8'h05, 8'h01);
		host.put(8'h08, 8'h21);
		host.put(8'h05, 8'h02);
		host.put(8'h08, 8'h02);
		rd(8'h08, 8'h02);
		host.put(8'h05, 8'h03);
		rd(8'h08, 8'h21);
		chk("pwr_state_a", 12'(PM_NORMAL), 12'(pwr_state[0]));
		commit();
		chk("pwr_state_a", 12'(PM_FULL), 12'(pwr_state[0]));
		chk("pwr_state_b", 12'(PM_STANDBY), 12'(pwr_state[1]));
		rd(8'hFF, 8'h00);
		host.put(8'h05, 8'h01);
		host.put(8'h08, 8'h20);
		host.put(8'h05, 8'h02);
		host.put(8'h08, 8'h00);
		host.put(8'h05, 8'h03);
		commit();
		pdwn_pin = 1'b1;
		repeat (3) @(negedge core_clk);
		chk("pwr_state_a", 12'(PM_STANDBY), 12'(pwr_state[0]));
		chk("pwr_state_b", 12'(PM_FULL), 12'(pwr_state[1]));
		pdwn_pin = 1'b0;
		repeat (3) @(negedge core_clk);
		chk("pwr_state_a", 12'(PM_NORMAL), 12'(pwr_state[0]));
		host.put(8'h09, 8'h00);
		for (int r = 0; r < 8; r++)
		begin
			host.put(8'h0B, 8'(r));
			commit();
			chk("dcs_active", 12'(r != 0), 12'(dcs_active));
			n = 0;
			repeat (8 * (r + 1))
			begin
				@(negedge core_clk);
				if (div_tick === 1'b1)
					n++;
			end
			chk("div_ticks", 12'h008, 12'(n));
		end
		// divide by 8; each pass is 16 cycles, so only the phase moves ticks
		for (int p = 0; p < 2; p++)
		begin
			host.put(8'h0B, p != 0 ? 8'h17 : 8'h07);
			commit();
			tp[p] = -1;
			for (int k = 0; k < 8; k++)
			begin
				@(negedge core_clk);
				if (div_tick === 1'b1)
					tp[p] = k;
			end
		end
		chk("div_phase", 12'((tp[0] + 2) % 8), 12'(tp[1]));
		host.put(8'h0B, 8'h00);
		for (int i = 0; i < 5; i++)
		begin
			host.put(8'h0D, 8'(tc[i]));
			commit();
			chk("dout_a", te[i], dout[0]);
			chk("dout_b", i == 0 ? 12'h456 : te[i], dout[1]);
			chk("test_active", 12'(tc[i] != 0 ? 3 : 0), 12'(test_active));
		end
		// checkerboard and toggle complement, ramp counts up
		for (int i = 0; i < 5; i++)
		begin
			host.put(8'h0D, 8'(dc[i]));
			commit();
			prev = dout[0];
			@(negedge core_clk);
			if (i < 2)
				chk("dout_a", ~prev, dout[0]);
			if (i == 2)
				chk("dout_a", prev + 12'h001, dout[0]);
			chk("test_active", 12'h003, 12'(test_active));
		end
		host.put(8'h0D, 8'h08);
		commit();
		n = 0;
		repeat (8)
		begin
			@(negedge core_clk);
			if (dout[0] === user_words[3])
				n++;
		end
		chk("user_repeats", 12'h002, 12'(n));
		host.put(8'h0D, 8'h00);
		commit();
		host.put(8'h0D, 8'h88);
		commit();
		repeat (8) @(negedge core_clk);
		chk("dout_a", 12'h000, dout[0]);
		chk("test_active", 12'h003, 12'(test_active));
		give_verdict();
	end
endmodule // testbench

/* src/adc_control_register_bank.sv */
// control register bank with shadowing, clock divider and test patterns
`timescale 1ns/1ps
`include "adc_ctrl_consts.svh"
// Functional notes
// - channel bits steer local writes to A and/or B; globals ignore them
// - local read with both channel bits set returns channel A value
// - transfer bit copies all master registers to active at once
// - shadowed writes act only on transfer; transfer bit self-clears
// - power field: 00 normal, 01 full down, 10 standby, 11 reserved
// - pin function bit: clear gives full down, set gives standby
// - clock divider ratio divides by field value plus one
// - nonzero ratio forces stabilizer on; enable bit resets set
// - phase field delays divided clock by 0 to 7 input cycles
// - four-bit test selector codes, ramp on final code
// - bit 7 set plays user pattern once then zeros
// - any test mode replaces samples on the outputs
module adc_control_register_bank
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// register access from the serial port
	input wire adc_ctrl_pkg::reg_req_t req,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	// power-down pin
	input wire logic pdwn_pin,
	// converter data
	input wire logic [1:0][11:0] sample,
	input wire logic [3:0][11:0] user_words,
	// applied settings and outputs
	output adc_ctrl_pkg::pwr_mode_t [1:0] pwr_state,
	output logic dcs_active,
	output logic div_tick,
	output logic [1:0] test_active,
	output logic [1:0][11:0] dout
);
	import adc_ctrl_pkg::*;

	// ****************
	// helpers
	// ****************
	function automatic pwr_reg_t cln_pwr(input logic [7:0] b);
		pwr_reg_t r;
		r = pwr_reg_t'(b);
		r.rsv7 = '0;
		r.rsv4 = '0;
		return r;
	endfunction

	function automatic cdiv_reg_t cln_cdiv(input logic [7:0] b);
		cdiv_reg_t r;
		r = cdiv_reg_t'(b);
		r.rsv = '0;
		return r;
	endfunction

	function automatic test_reg_t cln_test(input logic [7:0] b);
		test_reg_t r;
		r = test_reg_t'(b);
		r.rsv6 = 1'b0;
		return r;
	endfunction

	function automatic logic [22:0] pnl_next(input logic [22:0] x);
		return {x[21:0], x[22] ^ x[`PNL_TAP]};
	endfunction

	function automatic logic [8:0] pns_next(input logic [8:0] x);
		return {x[7:0], x[8] ^ x[`PNS_TAP]};
	endfunction

	// ****************
	// register file
	// ****************
	logic [1:0] chsel_q, chsel_d;
	pwr_reg_t [1:0] m_pwr_q, m_pwr_d, a_pwr_q, a_pwr_d;
	test_reg_t [1:0] m_test_q, m_test_d, a_test_q, a_test_d;
	gclk_reg_t m_gclk_q, m_gclk_d, a_gclk_q, a_gclk_d;
	cdiv_reg_t m_cdiv_q, m_cdiv_d, a_cdiv_q, a_cdiv_d;
	logic [7:0] rdata_q, rdata_d;
	logic rvalid_q, rvalid_d;
	logic xfer;
	logic rd_ch;

	// transfer is a strobe, so the bit never holds and reads zero
	assign xfer = req.wr && req.addr == `A_XFER && req.wdata[`B_XFER];
	// both bits set reads channel A
	assign rd_ch = !chsel_q[`B_CHA] && chsel_q[`B_CHB];

	always_comb
	begin
		chsel_d = chsel_q;
		m_pwr_d = m_pwr_q;
		m_test_d = m_test_q;
		m_gclk_d = m_gclk_q;
		m_cdiv_d = m_cdiv_q;
		a_pwr_d = a_pwr_q;
		a_test_d = a_test_q;
		a_gclk_d = a_gclk_q;
		a_cdiv_d = a_cdiv_q;
		rdata_d = rdata_q;
		rvalid_d = 1'b0;
		if (req.wr)
		begin
			case (req.addr)
				`A_CHSEL: chsel_d = req.wdata[1:0];
				`A_PWR:
				begin
					for (int c = 0; c < 2; c++)
						if (chsel_q[c])
							m_pwr_d[c] = cln_pwr(req.wdata);
				end
				`A_TEST:
				begin
					for (int c = 0; c < 2; c++)
						if (chsel_q[c])
							m_test_d[c] = cln_test(req.wdata);
				end
				`A_GCLK: m_gclk_d = gclk_reg_t'({7'h00, req.wdata[0]});
				`A_CDIV: m_cdiv_d = cln_cdiv(req.wdata);
				default: ;
			endcase
		end
		if (xfer)
		begin
			a_pwr_d = m_pwr_q;
			a_test_d = m_test_q;
			a_gclk_d = m_gclk_q;
			a_cdiv_d = m_cdiv_q;
		end
		if (req.rd)
		begin
			rvalid_d = 1'b1;
			case (req.addr)
				`A_CHSEL: rdata_d = {6'h00, chsel_q};
				`A_PWR: rdata_d = m_pwr_q[rd_ch];
				`A_TEST: rdata_d = m_test_q[rd_ch];
				`A_GCLK: rdata_d = m_gclk_q;
				`A_CDIV: rdata_d = m_cdiv_q;
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			chsel_q <= `RST_CHSEL;
			m_pwr_q <= {2{pwr_reg_t'(`RST_PWR)}};
			a_pwr_q <= {2{pwr_reg_t'(`RST_PWR)}};
			m_test_q <= {2{test_reg_t'(`RST_TEST)}};
			a_test_q <= {2{test_reg_t'(`RST_TEST)}};
			m_gclk_q <= gclk_reg_t'(`RST_GCLK);
			a_gclk_q <= gclk_reg_t'(`RST_GCLK);
			m_cdiv_q <= cdiv_reg_t'(`RST_CDIV);
			a_cdiv_q <= cdiv_reg_t'(`RST_CDIV);
			rdata_q <= 8'h00;
			rvalid_q <= 1'b0;
		end
		else
		begin
			chsel_q <= chsel_d;
			m_pwr_q <= m_pwr_d;
			a_pwr_q <= a_pwr_d;
			m_test_q <= m_test_d;
			a_test_q <= a_test_d;
			m_gclk_q <= m_gclk_d;
			a_gclk_q <= a_gclk_d;
			m_cdiv_q <= m_cdiv_d;
			a_cdiv_q <= a_cdiv_d;
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign reg_rvalid = rvalid_q;

	// ****************
	// power and clocking
	// ****************
	pwr_mode_t [1:0] pwr_q, pwr_d;
	logic [2:0] cnt_q, cnt_d;
	logic [`PH_LEN-1:0] dly_q, dly_d;
	logic tick_q, tick_d, dcs_q, dcs_d, tick_raw;

	assign tick_raw = cnt_q == 3'h0;

	always_comb
	begin
		for (int c = 0; c < 2; c++)
		begin
			// reserved code treated as normal, safest for the core
			if (pdwn_pin)
				pwr_d[c] = a_pwr_q[c].pin_stby ? PM_STANDBY : PM_FULL;
			else if (a_pwr_q[c].mode == PM_RSVD)
				pwr_d[c] = PM_NORMAL;
			else
				pwr_d[c] = a_pwr_q[c].mode;
		end
		// ratio r gives one tick every r+1 cycles
		cnt_d = (cnt_q >= a_cdiv_q.ratio) ? 3'h0 : cnt_q + 3'h1;
		dly_d = {dly_q[`PH_LEN-2:0], tick_raw};
		if (a_cdiv_q.phase == 3'h0)
			tick_d = tick_raw;
		else
			tick_d = dly_q[a_cdiv_q.phase - 3'h1];
		dcs_d = a_gclk_q.dcs_en || a_cdiv_q.ratio != 3'h0;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			pwr_q <= {PM_NORMAL, PM_NORMAL};
			cnt_q <= 3'h0;
			dly_q <= '0;
			tick_q <= 1'b0;
			dcs_q <= 1'b0;
		end
		else
		begin
			pwr_q <= pwr_d;
			cnt_q <= cnt_d;
			dly_q <= dly_d;
			tick_q <= tick_d;
			dcs_q <= dcs_d;
		end
	end

	assign pwr_state = pwr_q;
	assign div_tick = tick_q;
	assign dcs_active = dcs_q;

	// ****************
	// test pattern generator
	// ****************
	logic [1:0][22:0] pnl_q, pnl_d;
	logic [1:0][8:0] pns_q, pns_d;
	logic [1:0][11:0] ramp_q, ramp_d, dout_q, dout_d;
	logic [1:0][1:0] uidx_q, uidx_d;
	logic [1:0] tog_q, tog_d, udone_q, udone_d, act_q, act_d;

	always_comb
	begin
		pnl_d = pnl_q;
		pns_d = pns_q;
		ramp_d = ramp_q;
		uidx_d = uidx_q;
		tog_d = tog_q;
		udone_d = udone_q;
		dout_d = dout_q;
		for (int c = 0; c < 2; c++)
		begin
			act_d[c] = a_test_q[c].sel != TS_OFF;
			if (tick_q)
			begin
				pnl_d[c] = a_test_q[c].rst_long ? `PNL_SEED
					: pnl_next(pnl_q[c]);
				pns_d[c] = a_test_q[c].rst_short ? `PNS_SEED
					: pns_next(pns_q[c]);
				tog_d[c] = ~tog_q[c];
				ramp_d[c] = ramp_q[c] + 12'h001;
				case (a_test_q[c].sel)
					TS_OFF: dout_d[c] = sample[c];
					TS_MID: dout_d[c] = `MIDSCALE;
					TS_POSFS: dout_d[c] = `FULLSCALE;
					TS_NEGFS: dout_d[c] = `ZEROSCALE;
					TS_CHECK: dout_d[c] = tog_q[c] ? `CHECK_A : `CHECK_B;
					TS_PNL: dout_d[c] = pnl_q[c][11:0];
					TS_PNS: dout_d[c] = {3'h0, pns_q[c]};
					TS_TOGGLE: dout_d[c] = tog_q[c] ? `FULLSCALE : `ZEROSCALE;
					TS_USER:
					begin
						// single mode ends on zeros after the last word
						dout_d[c] = udone_q[c] ? `ZEROSCALE
							: user_words[uidx_q[c]];
						if (!udone_q[c])
						begin
							uidx_d[c] = uidx_q[c] + 2'h1;
							if (uidx_q[c] == `USER_LAST && a_test_q[c].single)
								udone_d[c] = 1'b1;
						end
					end
					TS_RAMP: dout_d[c] = ramp_q[c];
					default: dout_d[c] = `ZEROSCALE;
				endcase
			end
			if (a_test_q[c].sel != TS_USER)
			begin
				uidx_d[c] = 2'h0;
				udone_d[c] = 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			pnl_q <= {2{`PNL_SEED}};
			pns_q <= {2{`PNS_SEED}};
			ramp_q <= '0;
			uidx_q <= '0;
			tog_q <= '0;
			udone_q <= '0;
			act_q <= '0;
			dout_q <= '0;
		end
		else
		begin
			pnl_q <= pnl_d;
			pns_q <= pns_d;
			ramp_q <= ramp_d;
			uidx_q <= uidx_d;
			tog_q <= tog_d;
			udone_q <= udone_d;
			act_q <= act_d;
			dout_q <= dout_d;
		end
	end

	assign test_active = act_q;
	assign dout = dout_q;

	// ****************
	// checks
	// ****************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	a_local_wr_mask: assert property (
		req.wr && req.addr == `A_PWR && !chsel_q[1] |=> $stable(m_pwr_q[1]))
		else $error("local write reached unselected channel");
	a_global_wr: assert property (
		req.wr && req.addr == `A_CDIV
		|=> m_cdiv_q == cln_cdiv($past(req.wdata)))
		else $error("global write lost");
	a_read_chan_a: assert property (
		req.rd && req.addr == `A_TEST && &chsel_q && !req.wr
		|=> reg_rvalid && reg_rdata == m_test_q[0])
		else $error("dual-select read not channel A");
	a_xfer_copy: assert property (
		xfer |=> a_pwr_q == $past(m_pwr_q) && a_cdiv_q == $past(m_cdiv_q))
		else $error("transfer did not copy");
	a_shadow_hold: assert property (
		!xfer |=> $stable(a_test_q) && $stable(a_gclk_q))
		else $error("active setting moved without transfer");
	a_pwr_full: assert property (
		!pdwn_pin && a_pwr_q[0].mode == PM_FULL |=> pwr_state[0] == PM_FULL)
		else $error("power field not applied");
	a_pin_stby: assert property (
		pdwn_pin && a_pwr_q[0].pin_stby |=> pwr_state[0] == PM_STANDBY)
		else $error("pin standby not applied");
	a_div_by_two: assert property (
		tick_raw && a_cdiv_q.ratio == 3'h1 && !xfer
		|=> !tick_raw ##1 tick_raw)
		else $error("divide by two wrong");
	a_dcs_force: assert property (
		a_cdiv_q.ratio != 3'h0 |=> dcs_active)
		else $error("stabilizer not forced");
	a_phase_two: assert property (
		tick_raw && a_cdiv_q.phase == 3'h2 && !xfer ##1 !xfer [*2]
		|=> div_tick)
		else $error("phase delay wrong");
	a_pos_fs: assert property (
		tick_q && a_test_q[0].sel == TS_POSFS |=> dout[0] == `FULLSCALE)
		else $error("positive full scale wrong");
	a_single_zero: assert property (
		tick_q && udone_q[0] && a_test_q[0].sel == TS_USER
		|=> dout[0] == `ZEROSCALE)
		else $error("single pattern not zero");
	a_off_pass: assert property (
		tick_q && a_test_q[0].sel == TS_OFF |=> dout[0] == $past(sample[0]))
		else $error("samples not passed");

	c_transfer: cover property (xfer ##1 a_cdiv_q.ratio != 3'h0);
	c_user_done: cover property (tick_q && udone_q[0]);
	c_pin_stby: cover property (pwr_state[1] == PM_STANDBY);
endmodule // adc_control_register_bank

/* src/adc_ctrl_consts.svh */
// constants for the converter control register bank
`ifndef ADC_CTRL_CONSTS_SVH
`define ADC_CTRL_CONSTS_SVH
// ****************
// addresses
// ****************
`define A_CHSEL 8'h05
`define A_PWR 8'h08
`define A_GCLK 8'h09
`define A_CDIV 8'h0B
`define A_TEST 8'h0D
`define A_XFER 8'hFF
// ****************
// reset values and bit positions
// ****************
`define RST_CHSEL 2'h3
`define RST_PWR 8'h00
`define RST_GCLK 8'h01
`define RST_CDIV 8'h00
`define RST_TEST 8'h00
`define B_XFER 0
`define B_CHA 0
`define B_CHB 1
// ****************
// pattern values
// ****************
`define MIDSCALE 12'h800
`define FULLSCALE 12'hFFF
`define ZEROSCALE 12'h000
`define CHECK_A 12'hAAA
`define CHECK_B 12'h555
`define PNL_SEED 23'h7FFFFF
`define PNL_TAP 17
`define PNS_SEED 9'h1FF
`define PNS_TAP 4
`define USER_LAST 2'h3
`define PH_LEN 7
`endif

/* src/adc_ctrl_pkg.sv */
// types of the converter control register bank
package adc_ctrl_pkg;
	typedef enum logic [1:0] {
		PM_NORMAL = 2'b00,
		PM_FULL = 2'b01,
		PM_STANDBY = 2'b10,
		PM_RSVD = 2'b11
	} pwr_mode_t;
	typedef enum logic [3:0] {
		TS_OFF = 4'b0000,
		TS_MID = 4'b0001,
		TS_POSFS = 4'b0010,
		TS_NEGFS = 4'b0011,
		TS_CHECK = 4'b0100,
		TS_PNL = 4'b0101,
		TS_PNS = 4'b0110,
		TS_TOGGLE = 4'b0111,
		TS_USER = 4'b1000,
		TS_RAMP = 4'b1111
	} test_sel_t;
	typedef struct packed {
		logic [1:0] rsv7;
		logic pin_stby;
		logic [2:0] rsv4;
		pwr_mode_t mode;
	} pwr_reg_t;
	typedef struct packed {
		logic [6:0] rsv;
		logic dcs_en;
	} gclk_reg_t;
	typedef struct packed {
		logic [1:0] rsv;
		logic [2:0] phase;
		logic [2:0] ratio;
	} cdiv_reg_t;
	typedef struct packed {
		logic single;
		logic rsv6;
		logic rst_long;
		logic rst_short;
		test_sel_t sel;
	} test_reg_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;
endpackage
